// ---- logic/cfd_cfg_if.sv ----
// configuration bundle from the register file to the timing selector
`timescale 1ns/1ps
`default_nettype none
interface cfd_cfg_if #(
    parameter int TIMING_W = 32
);
    logic                  arb_nominal;     // arbitration uses nominal timing
    logic                  brs_en;          // data-phase rate switch enabled
    logic                  fd_en;           // flexible-data-rate format
    logic [15:0]           legacy_timing;   // legacy pair, high byte is _1
    logic [TIMING_W-1:0]   nominal_timing;  // nominal bit timing word
    logic [TIMING_W-1:0]   data_timing;     // data-phase timing and sample point

    modport ctrl (output arb_nominal, brs_en, fd_en, legacy_timing, nominal_timing, data_timing);
    modport sel  (input arb_nominal, brs_en, fd_en, legacy_timing, nominal_timing, data_timing);
endinterface
`default_nettype wire

// ---- logic/cfd_ctrl.sv ----
// fd frame mode control: register slave, reset-mode guard and fd status capture
//
// Design decisions made here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module cfd_ctrl #(
    parameter int TIMING_W = 32  // nominal and data timing word width
) (
    input  wire logic                        core_clk,         // core clock, 100 MHz
    input  wire logic                        arst_n,           // async reset, active low
    input  wire logic [cfd_pkg::ADDR_W-1:0]  avs_address,      // byte address
    input  wire logic                        avs_read,         // read request
    input  wire logic                        avs_write,        // write request
    input  wire logic [cfd_pkg::DATA_W-1:0]  avs_writedata,    // write data
    input  wire logic [cfd_pkg::BE_W-1:0]    avs_byteenable,   // byte lanes
    output logic      [cfd_pkg::DATA_W-1:0]  avs_readdata,     // read data
    output logic                             avs_waitrequest,  // slave stall
    input  wire logic                        data_phase,       // engine in data phase
    input  wire logic [cfd_pkg::EVT_W-1:0]   fd_err_evt,       // fd error event pulses
    input  wire logic [cfd_pkg::STATE_W-1:0] op_state,         // engine operating state
    output logic                             ctrl_in_reset,    // reset-mode bit
    output logic                             fd_format,        // fd frame format on
    output logic                             brs_enable,       // rate switch enabled
    output logic                             iso_format,       // iso fd format select
    output logic                             no_retransmit,    // auto retransmit off
    output logic                             restricted_mode,  // restricted operation
    output logic      [TIMING_W-1:0]         arb_timing,       // arbitration timing word
    output logic      [TIMING_W-1:0]         phase_timing      // timing for current bit
);

    // the legacy pair fills 16 bits and the bus carries 32
    if (TIMING_W < 16 || TIMING_W > cfd_pkg::DATA_W) begin : g_bad_width
        $error("TIMING_W must lie between 16 and 32");
    end

    // register state
    logic                              mode_rst_r;
    logic [cfd_pkg::FDCTRL_W-1:0]      fdctrl_r;
    logic [cfd_pkg::EVT_W-1:0]         fd_evt_r;
    logic [cfd_pkg::STATE_W-1:0]       fd_state_r;
    logic [cfd_pkg::LBT_W-1:0]         lbt0_r;
    logic [cfd_pkg::LBT_W-1:0]         lbt1_r;
    logic [TIMING_W-1:0]               nbt_r;
    logic [TIMING_W-1:0]               dbt_r;
    logic                              wait_r;
    logic [cfd_pkg::DATA_W-1:0]        rdata_r;
    logic [cfd_pkg::DATA_W-1:0]        rdata_nxt;

    // bus decode
    logic                              wr_go;
    logic                              rd_go;
    logic [5:0]                        word_sel;
    logic                              sel_mode;
    logic                              sel_lbt0;
    logic                              sel_lbt1;
    logic                              sel_nbt;
    logic                              sel_dbt;
    logic                              sel_fdctrl;
    logic                              sel_fdstat;
    logic [cfd_pkg::DATA_W-1:0]        wmask;
    logic [cfd_pkg::EVT_W-1:0]         evt_clr;
    logic                              fdctrl_wr_ok;

    cfd_cfg_if #(.TIMING_W(TIMING_W)) cfg ();

    // a write lands at the edge where waitrequest is seen low
    assign wr_go    = avs_write && !wait_r;
    assign rd_go    = avs_read && wait_r;
    assign word_sel = avs_address[7:2];

    // word decode; the low two address bits are ignored
    always_comb begin
        sel_mode   = (word_sel == cfd_pkg::MODE_ADDR[7:2]);
        sel_lbt0   = (word_sel == cfd_pkg::LBT0_ADDR[7:2]);
        sel_lbt1   = (word_sel == cfd_pkg::LBT1_ADDR[7:2]);
        sel_nbt    = (word_sel == cfd_pkg::NBT_ADDR[7:2]);
        sel_dbt    = (word_sel == cfd_pkg::DBT_ADDR[7:2]);
        sel_fdctrl = (word_sel == cfd_pkg::FDCTRL_ADDR[7:2]);
        sel_fdstat = (word_sel == cfd_pkg::FDSTAT_ADDR[7:2]);
    end

    // byte-lane mask built per lane
    for (genvar i = 0; i < cfd_pkg::BE_W; i++) begin : g_wmask
        assign wmask[i*8 +: 8] = {8{avs_byteenable[i]}};
    end

    // mode bits accept writes only in reset mode
    assign fdctrl_wr_ok = wr_go && sel_fdctrl && avs_byteenable[0] && mode_rst_r;

    // write one to clear a sticky indicator
    assign evt_clr = (wr_go && sel_fdstat && avs_byteenable[0])
                     ? avs_writedata[cfd_pkg::EVT_W-1:0] : '0;

    // waitrequest: high when idle, low for exactly one cycle per request
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_r <= 1'b1;
        end else if (!wait_r) begin
            wait_r <= 1'b1;
        end else if (avs_read || avs_write) begin
            wait_r <= 1'b0;
        end
    end

    // read mux; unmapped words and reserved bits read as zero
    always_comb begin
        rdata_nxt = '0;
        case (1'b1)
            sel_mode: begin
                rdata_nxt[cfd_pkg::MODE_RST_BIT] = mode_rst_r;
            end
            sel_lbt0: begin
                rdata_nxt[cfd_pkg::LBT_W-1:0] = lbt0_r;
            end
            sel_lbt1: begin
                rdata_nxt[cfd_pkg::LBT_W-1:0] = lbt1_r;
            end
            sel_nbt: begin
                rdata_nxt[TIMING_W-1:0] = nbt_r;
            end
            sel_dbt: begin
                rdata_nxt[TIMING_W-1:0] = dbt_r;
            end
            sel_fdctrl: begin
                rdata_nxt[cfd_pkg::FDCTRL_W-1:0] = fdctrl_r;
            end
            sel_fdstat: begin
                rdata_nxt[cfd_pkg::EVT_W-1:0] = fd_evt_r;
                rdata_nxt[cfd_pkg::STATE_LSB +: cfd_pkg::STATE_W] = fd_state_r;
            end
            default: begin
                rdata_nxt = '0;
            end
        endcase
    end

    // read data is captured on the first cycle and stands through the answer
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r <= '0;
        end else if (rd_go) begin
            rdata_r <= rdata_nxt;
        end
    end

    // reset-mode bit, writable at any time; starts in reset
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_rst_r <= cfd_pkg::MODE_RST_RESET;
        end else if (wr_go && sel_mode && avs_byteenable[0]) begin
            mode_rst_r <= avs_writedata[cfd_pkg::MODE_RST_BIT];
        end
    end

    // fd frame control; writes outside reset mode are dropped silently
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            fdctrl_r <= cfd_pkg::FDCTRL_RESET;
        end else if (fdctrl_wr_ok) begin
            fdctrl_r <= avs_writedata[cfd_pkg::FDCTRL_W-1:0];
        end
    end

    // legacy timing pair
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            lbt0_r <= cfd_pkg::LBT_RESET;
            lbt1_r <= cfd_pkg::LBT_RESET;
        end else if (wr_go && avs_byteenable[0]) begin
            if (sel_lbt0) begin
                lbt0_r <= avs_writedata[cfd_pkg::LBT_W-1:0];
            end
            if (sel_lbt1) begin
                lbt1_r <= avs_writedata[cfd_pkg::LBT_W-1:0];
            end
        end
    end

    // nominal and data-phase timing words honour every byte lane
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            nbt_r <= '0;
            dbt_r <= '0;
        end else if (wr_go) begin
            if (sel_nbt) begin
                nbt_r <= (nbt_r & ~wmask[TIMING_W-1:0])
                         | (avs_writedata[TIMING_W-1:0] & wmask[TIMING_W-1:0]);
            end
            if (sel_dbt) begin
                dbt_r <= (dbt_r & ~wmask[TIMING_W-1:0])
                         | (avs_writedata[TIMING_W-1:0] & wmask[TIMING_W-1:0]);
            end
        end
    end

    // sticky indicators: in fd mode a new event wins over a clear in the same cycle
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            fd_evt_r <= cfd_pkg::EVT_RESET;
        end else if (fdctrl_r[cfd_pkg::FDEN_BIT]) begin
            fd_evt_r <= (fd_evt_r & ~evt_clr) | fd_err_evt;
        end else begin
            fd_evt_r <= fd_evt_r & ~evt_clr;
        end
    end

    // operating state snapshot, frozen while classic format is chosen
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            fd_state_r <= cfd_pkg::STATE_RESET;
        end else if (fdctrl_r[cfd_pkg::FDEN_BIT]) begin
            // state tracked only in fd mode
            fd_state_r <= op_state;
        end
    end

    // configuration handed to the timing selector
    assign cfg.arb_nominal    = fdctrl_r[cfd_pkg::EXTBT_BIT];
    assign cfg.brs_en         = fdctrl_r[cfd_pkg::BRSEN_BIT];
    assign cfg.fd_en          = fdctrl_r[cfd_pkg::FDEN_BIT];
    assign cfg.legacy_timing  = {lbt1_r, lbt0_r};
    assign cfg.nominal_timing = nbt_r;
    assign cfg.data_timing    = dbt_r;

    cfd_phase_sel #(
        .TIMING_W     (TIMING_W)
    ) u_phase_sel (
        .core_clk     (core_clk),
        .arst_n       (arst_n),
        .cfg          (cfg.sel),
        .data_phase   (data_phase),
        .arb_timing   (arb_timing),
        .phase_timing (phase_timing)
    );

    // outputs straight from the control flops
    assign avs_readdata    = rdata_r;
    assign avs_waitrequest = wait_r;
    assign ctrl_in_reset   = mode_rst_r;
    assign fd_format       = fdctrl_r[cfd_pkg::FDEN_BIT];
    assign brs_enable      = fdctrl_r[cfd_pkg::BRSEN_BIT];
    assign iso_format      = fdctrl_r[cfd_pkg::ISO_BIT];
    assign no_retransmit   = fdctrl_r[cfd_pkg::NORETX_BIT];
    assign restricted_mode = fdctrl_r[cfd_pkg::RESTRICT_BIT];

    // bus answer comes one cycle after the request is seen
    a_bus_answer_time: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("waitrequest not low for exactly one cycle");

    a_ctrl_locked_run: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (!mode_rst_r && !(wr_go && sel_mode)) |=> $stable(fdctrl_r))
        else $error("mode bits changed outside reset mode");

    a_ctrl_write_reset: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (wr_go && sel_fdctrl && avs_byteenable[0] && mode_rst_r)
            |=> fdctrl_r == $past(avs_writedata[cfd_pkg::FDCTRL_W-1:0]))
        else $error("mode bits not written in reset mode");

    a_format_write: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (fdctrl_wr_ok && avs_writedata[cfd_pkg::FDEN_BIT]) |=> fd_format ##1 fd_format)
        else $error("fd format not taken from format enable bit");

    a_format_classic: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (fdctrl_wr_ok && !avs_writedata[cfd_pkg::FDEN_BIT]) |=> !fd_format)
        else $error("classic format not taken from format enable bit");

    a_status_frozen: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        !fdctrl_r[cfd_pkg::FDEN_BIT] |=> (fd_evt_r & ~$past(fd_evt_r)) == '0)
        else $error("fd indicator set in classic mode");

    a_status_capture: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (fdctrl_r[cfd_pkg::FDEN_BIT] && fd_err_evt[0]) |=> fd_evt_r[0])
        else $error("fd indicator event lost in fd mode");

    // the state snapshot must not drift while classic format is chosen
    a_state_frozen: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        !fdctrl_r[cfd_pkg::FDEN_BIT] |=> $stable(fd_state_r))
        else $error("operating state snapshot moved in classic mode");

    // a clear landing with an event must not swallow that event
    a_status_set_wins: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (fdctrl_r[cfd_pkg::FDEN_BIT] && (fd_err_evt & evt_clr) != '0)
            |=> (fd_evt_r & $past(fd_err_evt)) == $past(fd_err_evt))
        else $error("fd indicator event lost to a clear");

endmodule
`default_nettype wire

// ---- logic/cfd_phase_sel.sv ----
// picks the bit timing word for the arbitration and data phases
`timescale 1ns/1ps
`default_nettype none
module cfd_phase_sel #(
    parameter int TIMING_W = 32
) (
    input  wire logic                core_clk,     // core clock
    input  wire logic                arst_n,       // async reset, active low
    cfd_cfg_if.sel                   cfg,          // configuration from registers
    input  wire logic                data_phase,   // protocol engine is in data phase
    output logic [TIMING_W-1:0]      arb_timing,   // timing for arbitration phase
    output logic [TIMING_W-1:0]      phase_timing  // timing for the current bit
);

    logic [TIMING_W-1:0] legacy_ext;
    logic [TIMING_W-1:0] arb_sel;

    // arbitration source select
    always_comb begin
        legacy_ext = TIMING_W'(cfg.legacy_timing);
        arb_sel = cfg.arb_nominal ? cfg.nominal_timing : legacy_ext;
    end

    // registered so the timing outputs never glitch with register writes
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            arb_timing <= '0;
        end else begin
            arb_timing <= arb_sel;
        end
    end

    // classic frames carry no switch bit, so fd_en gates the rate change too
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_timing <= '0;
        end else begin
            phase_timing <= (data_phase && cfg.brs_en && cfg.fd_en) ? cfg.data_timing : arb_sel;
        end
    end

    a_arb_legacy_sel: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        !cfg.arb_nominal |=> arb_timing == $past(legacy_ext))
        else $error("arbitration timing not taken from legacy pair");

    a_arb_nominal_sel: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        cfg.arb_nominal |=> arb_timing == $past(cfg.nominal_timing))
        else $error("arbitration timing not taken from nominal register");

    a_no_rate_switch: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        !cfg.brs_en |=> phase_timing == arb_timing)
        else $error("rate switched while switch disabled");

    a_data_phase_timing: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (cfg.brs_en && cfg.fd_en && data_phase) |=> phase_timing == $past(cfg.data_timing))
        else $error("data phase not timed from data timing register");

endmodule
`default_nettype wire

// ---- logic/cfd_pkg.sv ----
// constants for the can fd frame mode control block
package cfd_pkg;

    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int BE_W   = 4;

    // register indices; byte address is four times the index
    localparam logic [7:0] MODE_IDX   = 8'h00;
    localparam logic [7:0] LBT0_IDX   = 8'h01;
    localparam logic [7:0] LBT1_IDX   = 8'h02;
    localparam logic [7:0] NBT_IDX    = 8'h03;
    localparam logic [7:0] DBT_IDX    = 8'h04;
    localparam logic [7:0] FDCTRL_IDX = 8'h24;
    localparam logic [7:0] FDSTAT_IDX = 8'h25;

    localparam logic [7:0] MODE_ADDR   = {MODE_IDX[5:0], 2'b00};
    localparam logic [7:0] LBT0_ADDR   = {LBT0_IDX[5:0], 2'b00};
    localparam logic [7:0] LBT1_ADDR   = {LBT1_IDX[5:0], 2'b00};
    localparam logic [7:0] NBT_ADDR    = {NBT_IDX[5:0], 2'b00};
    localparam logic [7:0] DBT_ADDR    = {DBT_IDX[5:0], 2'b00};
    localparam logic [7:0] FDCTRL_ADDR = {FDCTRL_IDX[5:0], 2'b00};
    localparam logic [7:0] FDSTAT_ADDR = {FDSTAT_IDX[5:0], 2'b00};

    // mode register layout
    localparam int MODE_RST_BIT = 0;
    localparam logic MODE_RST_RESET = 1'b1;

    // fd_frame_control field positions
    localparam int FDCTRL_W     = 6;
    localparam int FDEN_BIT     = 0;
    localparam int BRSEN_BIT    = 1;
    localparam int EXTBT_BIT    = 2;
    localparam int ISO_BIT      = 3;
    localparam int NORETX_BIT   = 4;
    localparam int RESTRICT_BIT = 5;
    localparam logic [FDCTRL_W-1:0] FDCTRL_RESET = 6'h00;

    // fd status layout: five sticky indicators, operating state on top
    localparam int EVT_W       = 5;
    localparam int STATE_LSB   = 6;
    localparam int STATE_W     = 2;
    localparam logic [EVT_W-1:0]   EVT_RESET   = 5'h00;
    localparam logic [STATE_W-1:0] STATE_RESET = 2'h0;

    // legacy timing register width
    localparam int LBT_W = 8;
    localparam logic [LBT_W-1:0] LBT_RESET = 8'h00;

endpackage

// ---- testbench/cfd_engine_model.sv ----
// behavioural protocol engine feeding phase, fd error events and state
`timescale 1ns/1ps
`default_nettype none
module cfd_engine_model (
    input  wire logic                        core_clk,   // core clock
    input  wire logic                        arst_n,     // async reset, active low
    input  wire logic                        phase_cmd,  // bench asks for data phase
    input  wire logic [cfd_pkg::EVT_W-1:0]   evt_cmd,    // bench event request, one cycle
    input  wire logic [cfd_pkg::STATE_W-1:0] state_cmd,  // bench requested state
    output logic                             data_phase, // to block
    output logic      [cfd_pkg::EVT_W-1:0]   fd_err_evt, // one-cycle event pulses
    output logic      [cfd_pkg::STATE_W-1:0] op_state    // engine state level
);
    // everything launched from the clock, like the real engine
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            data_phase <= 1'b0;
            fd_err_evt <= '0;
            op_state   <= '0;
        end else begin
            data_phase <= phase_cmd;
            fd_err_evt <= evt_cmd;
            op_state   <= state_cmd;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// self-checking bench for the fd frame mode control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
    logic        core_clk, arst_n, rd_v, wr_v, wait_v, phase_cmd, in_rst;
    logic        fd_v, brs_v, iso_v, nor_v, res_v, dph;
    logic [7:0]  addr_v;
    logic [31:0] wd_v, rdat_v, arb_v, pht_v, rd, lfsr, t0, t1, tn, td, ea;
    logic [3:0]  be_v;
    logic [4:0]  evt_cmd, evt, ev_p;
    logic [1:0]  state_cmd, ost;
    logic [5:0]  v;
    int          error_cnt, total_checks, cyc;

    cfd_ctrl i_dut (.core_clk(core_clk), .arst_n(arst_n), .avs_address(addr_v),
        .avs_read(rd_v), .avs_write(wr_v), .avs_writedata(wd_v), .avs_byteenable(be_v),
        .avs_readdata(rdat_v), .avs_waitrequest(wait_v), .data_phase(dph),
        .fd_err_evt(evt), .op_state(ost), .ctrl_in_reset(in_rst), .fd_format(fd_v),
        .brs_enable(brs_v), .iso_format(iso_v), .no_retransmit(nor_v),
        .restricted_mode(res_v), .arb_timing(arb_v), .phase_timing(pht_v));
    cfd_engine_model i_eng (.core_clk(core_clk), .arst_n(arst_n), .phase_cmd(phase_cmd),
        .evt_cmd(evt_cmd), .state_cmd(state_cmd), .data_phase(dph), .fd_err_evt(evt),
        .op_state(ost));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // 32-bit lfsr seeded with 94
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction

    // expected arbitration word: legacy pair is only 16 bits wide
    function automatic logic [31:0] exp_arb(input logic ext, input logic [31:0] a,
                                            input logic [31:0] b, input logic [31:0] n);
        return ext ? n : {16'h0000, b[7:0], a[7:0]};
    endfunction

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // hang guard, the whole run needs well under 1000 cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc > 2000) begin
            error_cnt++;
            print_verdict();
        end
    end

    // bus access: hold until waitrequest seen low, then release and pass an edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        addr_v <= a;
        wd_v   <= d;
        if (w) wr_v <= 1'b1;
        else rd_v <= 1'b1;
        do @(posedge core_clk); while (wait_v !== 1'b0);
        rd = rdat_v;
        wr_v <= 1'b0;
        rd_v <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic done(input string s);
        $display("test %s done", s);
    endtask

    initial begin
        lfsr = 32'h0000005e;
        {arst_n, rd_v, wr_v, phase_cmd, addr_v, wd_v, evt_cmd, state_cmd} = '0;
        be_v = 4'hf;
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        `CHK(in_rst, 1'b1)
        `CHK({fd_v, brs_v, iso_v, nor_v, res_v}, 5'h00)
        bus(0, cfd_pkg::FDCTRL_ADDR, 0);
        `CHK(rd[5:0], cfd_pkg::FDCTRL_RESET)
        bus(0, 8'hfc, 0);
        `CHK(rd, 32'h0)
        done("reset");

        // the bench sets these fields in reset mode, then writes their inverse outside reset mode and checks it is dropped
        for (int k = 0; k < 4; k++) begin
            v = rnd();
            bus(1, cfd_pkg::FDCTRL_ADDR, {26'h0, v});
            `CHK({res_v, nor_v, iso_v, brs_v, fd_v}, {v[5:3], v[1:0]})
            bus(1, cfd_pkg::MODE_ADDR, 32'h0);
            `CHK(in_rst, 1'b0)
            bus(1, cfd_pkg::FDCTRL_ADDR, {26'h0, ~v});
            bus(0, cfd_pkg::FDCTRL_ADDR, 0);
            `CHK(rd[5:0], v)
            `CHK(fd_v, v[0])
            bus(1, cfd_pkg::MODE_ADDR, 32'h1);
        end
        done("reset_gate");

        // every select, switch and format combination
        for (int m = 0; m < 8; m++) begin
            t0 = rnd();
            t1 = rnd();
            tn = rnd();
            td = rnd();
            bus(1, cfd_pkg::LBT0_ADDR, t0);
            bus(1, cfd_pkg::LBT1_ADDR, t1);
            bus(1, cfd_pkg::NBT_ADDR, tn);
            bus(1, cfd_pkg::DBT_ADDR, td);
            bus(1, cfd_pkg::FDCTRL_ADDR, m);
            // timing words are registered one cycle behind the mode bits
            @(posedge core_clk);
            ea = exp_arb(m[2], t0, t1, tn);
            `CHK(arb_v, ea)
            `CHK(pht_v, ea)
            `CHK(fd_v, m[0])
            phase_cmd <= 1'b1;
            repeat (3) @(posedge core_clk);
            `CHK(pht_v, (m[1] && m[0]) ? td : ea)
            `CHK(arb_v, ea)
            phase_cmd <= 1'b0;
            repeat (3) @(posedge core_clk);
            `CHK(pht_v, ea)
        end
        done("timing");

        // status frozen with fd off, captured with fd on
        bus(1, cfd_pkg::FDCTRL_ADDR, 32'h0);
        state_cmd <= 2'h3;
        evt_cmd   <= 5'h1f;
        @(posedge core_clk);
        evt_cmd   <= 5'h00;
        repeat (3) @(posedge core_clk);
        bus(0, cfd_pkg::FDSTAT_ADDR, 0);
        `CHK(rd[7:0], 8'h00)
        bus(1, cfd_pkg::FDCTRL_ADDR, 32'h1);
        ev_p = rnd();
        state_cmd <= 2'h2;
        evt_cmd   <= ev_p;
        @(posedge core_clk);
        evt_cmd   <= 5'h00;
        repeat (3) @(posedge core_clk);
        bus(0, cfd_pkg::FDSTAT_ADDR, 0);
        `CHK(rd[7:0], {2'h2, 1'b0, ev_p})
        bus(1, cfd_pkg::FDSTAT_ADDR, 32'h1f);
        bus(0, cfd_pkg::FDSTAT_ADDR, 0);
        `CHK(rd[4:0], 5'h00)
        // corner: an event arriving in the clearing cycle must survive the clear
        fork
            bus(1, cfd_pkg::FDSTAT_ADDR, 32'h1f);
            begin
                evt_cmd <= 5'h01;
                @(posedge core_clk);
                evt_cmd <= 5'h00;
            end
        join
        bus(0, cfd_pkg::FDSTAT_ADDR, 0);
        `CHK(rd[4:0], 5'h01)
        done("status");
        print_verdict();
    end
endmodule
`default_nettype wire
